// >>> logic/flc_host.sv
// host-side controller for an asynchronous parallel NOR flash: pin sequencing and command checks
// assumes requests from logic on MCLK; flash data and busy pins are asynchronous and are synchronised
//
// What this block does
// - hold reset minimum, wait recovery and wake-up
// - flash reset driven from system reset
// - erase is setup then confirm, same block
// - buffer: setup, count, N+1 data, confirm
// - check buffer available before sending count
// - host writes only defined command codes
`default_nettype none

module flc_host
   import flc_pkg::*;
#(
   parameter int RESET_LOW_MIN_NS = FLC_RST_LOW_NS,
   parameter int RESET_TO_WRITE_NS = FLC_RST_WRITE_NS,
   parameter int RESET_TO_READ_NS = FLC_RST_READ_NS,
   parameter bit BYTE_MODE = 1'b0
) (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic REQ_VALID,
   input wire flc_req_t REQ,
   output logic REQ_READY,
   output logic RSP_VALID,
   output logic RSP_ERR,
   output logic [FLC_DW-1:0] RSP_DATA,
   input wire logic PROGRAM_ALLOW,
   output flc_pins_t FLASH,
   input wire logic [FLC_DW-1:0] DQ_I,
   input wire logic BUSY_STATUS_PIN,
   output logic FLASH_BUSY
);
   // least times round up to whole cycles
   localparam int RST_LOW_CYC = (RESET_LOW_MIN_NS + FLC_CLK_NS - 1) / FLC_CLK_NS;
   localparam int WR_REC_CYC = (RESET_TO_WRITE_NS + FLC_CLK_NS - 1) / FLC_CLK_NS;
   localparam int RD_REC_CYC = (RESET_TO_READ_NS + FLC_CLK_NS - 1) / FLC_CLK_NS;
   localparam int REC_CYC = (WR_REC_CYC > RD_REC_CYC) ? WR_REC_CYC : RD_REC_CYC;
   localparam int SETUP_CYC = (FLC_SETUP_NS + FLC_CLK_NS - 1) / FLC_CLK_NS;
   localparam int WE_CYC = (FLC_WE_NS + FLC_CLK_NS - 1) / FLC_CLK_NS;
   // read strobe also covers the two-flop delay of the data synchroniser
   localparam int OE_CYC = (FLC_OE_NS + FLC_CLK_NS - 1) / FLC_CLK_NS + FLC_SYNC_CYC;
   localparam int HOLD_CYC = (FLC_HOLD_NS + FLC_CLK_NS - 1) / FLC_CLK_NS;
   localparam logic [4:0] NMAX = BYTE_MODE ? FLC_BUF_MAX_BYTE : FLC_BUF_MAX_WORD;

   flc_state_t s;
   flc_state_t n;
   logic taken;
   logic same_blk;

   function automatic logic code_defined(input logic [7:0] c);
      case (c)
         FLC_CMD_READ_ARRAY, FLC_CMD_READ_ID, FLC_CMD_READ_QUERY, FLC_CMD_READ_STATUS, FLC_CMD_CLEAR_STATUS,
         FLC_CMD_BUF_PROG, FLC_CMD_PROG_A, FLC_CMD_PROG_B, FLC_CMD_ERASE, FLC_CMD_SUSPEND, FLC_CMD_CONFIRM,
         FLC_CMD_CONFIG, FLC_CMD_LOCK, FLC_CMD_PROT_PROG: code_defined = 1'b1;
         default: code_defined = 1'b0;
      endcase
   endfunction : code_defined

   function automatic logic needs_program_enable_supply(input logic [7:0] c);
      case (c)
         FLC_CMD_BUF_PROG, FLC_CMD_PROG_A, FLC_CMD_PROG_B, FLC_CMD_ERASE, FLC_CMD_LOCK,
         FLC_CMD_PROT_PROG: needs_program_enable_supply = 1'b1;
         default: needs_program_enable_supply = 1'b0;
      endcase
   endfunction : needs_program_enable_supply

   // whether a write of code c is allowed at this point of a sequence
   function automatic logic legal_write(input flc_seq_t sq, input logic [7:0] c, input logic sb, input logic vp);
      case (sq)
         SQ_IDLE: legal_write = code_defined(c) && (vp || !needs_program_enable_supply(c));
         SQ_ERASE: legal_write = (c == FLC_CMD_CONFIRM) && sb;
         SQ_LOCK: legal_write = (c == FLC_CMD_LOCK_SET) || (c == FLC_CMD_CONFIRM);
         SQ_DATA, SQ_BUF_DATA: legal_write = 1'b1;
         SQ_BUF_WAIT: legal_write = 1'b0;
         SQ_BUF_CNT: legal_write = sb && (c <= {3'h0, NMAX});
         SQ_BUF_CONF: legal_write = (c == FLC_CMD_CONFIRM);
         default: legal_write = 1'b0;
      endcase
   endfunction : legal_write

   assign taken = REQ_VALID && s.rdy;
   assign same_blk = (REQ.addr[FLC_AW-1:FLC_BLK_LSB] == s.blk);

   always_comb begin
      n = s;
      n.rsp_valid = 1'b0;
      n.rsp_err = 1'b0;
      n.dq_s1 = DQ_I;
      n.dq_s2 = s.dq_s1;
      n.bz_s1 = BUSY_STATUS_PIN;
      n.bz_s2 = s.bz_s1;
      n.busy = !s.bz_s2;
      n.pins.program_enable_supply = PROGRAM_ALLOW;
      if (!s.pins.reset_powerdown_n) begin
         n.since = 16'h0000;
      end else if (s.since != 16'hffff) begin
         n.since = s.since + 16'h0001;
      end
      case (s.st)
         ST_RST: begin
            if (s.cnt >= 16'(RST_LOW_CYC - 1)) begin
               n.pins.reset_powerdown_n = 1'b1;
               n.st = ST_IDLE;
               n.cnt = 16'h0000;
               n.rsp_valid = 1'b1;
               n.seq = SQ_IDLE;
            end else begin
               n.cnt = s.cnt + 16'h0001;
            end
         end
         ST_IDLE: begin
            if (taken) begin
               n.req = REQ;
               if (REQ.op == FLC_OP_RESET) begin
                  // any running operation is aborted; contents it touched are suspect
                  n.st = ST_RST;
                  n.cnt = 16'h0000;
                  n.pins.reset_powerdown_n = 1'b0;
               end else if ((REQ.op == FLC_OP_WRITE) &&
                            !legal_write(s.seq, REQ.data[7:0], same_blk, PROGRAM_ALLOW)) begin
                  n.rsp_valid = 1'b1;
                  n.rsp_err = 1'b1;
               end else begin
                  n.st = ST_SETUP;
                  n.cnt = 16'h0000;
                  n.pins.chip_select_0 = 1'b0;
                  n.pins.addr = REQ.addr;
                  if (REQ.op == FLC_OP_WRITE) begin
                     n.pins.dq_oe = 1'b1;
                     if ((s.seq == SQ_DATA) || (s.seq == SQ_BUF_DATA)) begin
                        n.pins.dq_o = REQ.data;
                     end else begin
                        n.pins.dq_o = {8'h00, REQ.data[7:0]};
                     end
                  end
               end
            end
         end
         ST_SETUP: begin
            if (s.cnt >= 16'(SETUP_CYC - 1)) begin
               n.st = ST_STROBE;
               n.cnt = 16'h0000;
               if (s.req.op == FLC_OP_READ) begin
                  n.pins.oe_n = 1'b0;
               end else begin
                  n.pins.we_n = 1'b0;
               end
            end else begin
               n.cnt = s.cnt + 16'h0001;
            end
         end
         ST_STROBE: begin
            if (s.cnt >= 16'(((s.req.op == FLC_OP_READ) ? OE_CYC : WE_CYC) - 1)) begin
               // data stays driven past the write strobe rise, where the flash latches it
               n.pins.oe_n = 1'b1;
               n.pins.we_n = 1'b1;
               n.st = ST_HOLD;
               n.cnt = 16'h0000;
               if (s.req.op == FLC_OP_READ) begin
                  n.rsp_data = s.dq_s2;
               end
            end else begin
               n.cnt = s.cnt + 16'h0001;
            end
         end
         ST_HOLD: begin
            if (s.cnt >= 16'(HOLD_CYC - 1)) begin
               n.pins.chip_select_0 = 1'b1;
               n.pins.dq_oe = 1'b0;
               n.st = ST_IDLE;
               n.cnt = 16'h0000;
               n.rsp_valid = 1'b1;
               if (s.req.op == FLC_OP_READ) begin
                  if (s.seq == SQ_BUF_WAIT) begin
                     n.seq = s.rsp_data[FLC_READY_BIT] ? SQ_BUF_CNT : SQ_IDLE;
                  end
               end else begin
                  case (s.seq)
                     SQ_IDLE: begin
                        n.blk = s.req.addr[FLC_AW-1:FLC_BLK_LSB];
                        case (s.pins.dq_o[7:0])
                           FLC_CMD_ERASE: n.seq = SQ_ERASE;
                           FLC_CMD_BUF_PROG: n.seq = SQ_BUF_WAIT;
                           FLC_CMD_PROG_A, FLC_CMD_PROG_B, FLC_CMD_PROT_PROG: n.seq = SQ_DATA;
                           FLC_CMD_CONFIG: n.seq = SQ_DATA;
                           FLC_CMD_LOCK: n.seq = SQ_LOCK;
                           default: n.seq = SQ_IDLE;
                        endcase
                     end
                     SQ_BUF_CNT: begin
                        n.left = s.pins.dq_o[4:0];
                        n.seq = SQ_BUF_DATA;
                     end
                     SQ_BUF_DATA: begin
                        if (s.left == 5'h00) begin
                           n.seq = SQ_BUF_CONF;
                        end else begin
                           n.left = s.left - 5'h01;
                        end
                     end
                     default: n.seq = SQ_IDLE;
                  endcase
               end
            end else begin
               n.cnt = s.cnt + 16'h0001;
            end
         end
         default: n.st = ST_RST;
      endcase
      n.rdy = (n.st == ST_IDLE) && (s.since >= 16'(REC_CYC)) && !taken;
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s <= FLC_STATE_RST;
      end else begin
         s <= n;
      end
   end

   assign FLASH = s.pins;
   assign REQ_READY = s.rdy;
   assign RSP_VALID = s.rsp_valid;
   assign RSP_ERR = s.rsp_err;
   assign RSP_DATA = s.rsp_data;
   assign FLASH_BUSY = s.busy;

   chk_rst_low_hold: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $rose(FLASH.reset_powerdown_n) |-> $past(s.cnt) == 16'(RST_LOW_CYC - 1))
      else $error("reset released before minimum low time");
   chk_write_recovery: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $fell(FLASH.we_n) |-> s.since >= 16'(WR_REC_CYC))
      else $error("write strobe too soon after reset release");
   chk_read_wakeup: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $fell(FLASH.oe_n) |-> s.since >= 16'(RD_REC_CYC))
      else $error("read strobe too soon after reset release");
   chk_sys_reset: assert property (@(posedge MCLK) disable iff (1'b0)
      !ARST_N |-> !FLASH.reset_powerdown_n && FLASH.chip_select_0)
      else $error("flash not held in reset with system reset");
   chk_code_defined: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $fell(FLASH.we_n) && (s.seq == SQ_IDLE) |-> code_defined(FLASH.dq_o[7:0]))
      else $error("undefined command code written");
   chk_erase_confirm: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $fell(FLASH.we_n) && (s.seq == SQ_ERASE) |->
      (FLASH.dq_o[7:0] == FLC_CMD_CONFIRM) && (FLASH.addr[FLC_AW-1:FLC_BLK_LSB] == s.blk))
      else $error("erase setup not followed by confirm in same block");
   chk_buf_status: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $fell(FLASH.we_n) |-> s.seq != SQ_BUF_WAIT)
      else $error("buffer write before availability check");
   chk_buf_count: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $fell(FLASH.we_n) && (s.seq == SQ_BUF_CNT) |-> FLASH.dq_o[7:0] <= {3'h0, NMAX})
      else $error("buffer count out of range");
   chk_buf_confirm: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $fell(FLASH.we_n) && (s.seq == SQ_BUF_CONF) |-> FLASH.dq_o[7:0] == FLC_CMD_CONFIRM)
      else $error("buffer data not followed by confirm");
   chk_strobe_width: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $fell(FLASH.we_n) |-> !FLASH.we_n [*2] ##(WE_CYC - 1) FLASH.we_n && FLASH.dq_oe && !FLASH.chip_select_0)
      else $error("write strobe width or data hold wrong");
endmodule : flc_host

`default_nettype wire

// >>> logic/flc_pkg.sv
// constants, command codes and carrier types of the parallel NOR flash host controller
// assumes a single 125 MHz clock domain; the flash itself is reached only through its pins
`default_nettype none

package flc_pkg;
   localparam int FLC_CLK_NS = 8;
   localparam int FLC_AW = 24;
   localparam int FLC_DW = 16;
   localparam int FLC_BLK_LSB = 17;
   localparam int FLC_READY_BIT = 7;

   // pin timing figures in ns and synchroniser depth in cycles; plain defaults, tune to the part fitted
   localparam int FLC_RST_LOW_NS = 25000;
   localparam int FLC_RST_WRITE_NS = 1000;
   localparam int FLC_RST_READ_NS = 200;
   localparam int FLC_SETUP_NS = 20;
   localparam int FLC_WE_NS = 70;
   localparam int FLC_OE_NS = 150;
   localparam int FLC_HOLD_NS = 20;
   localparam int FLC_SYNC_CYC = 2;

   localparam logic [7:0] FLC_CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] FLC_CMD_READ_ID = 8'h90;
   localparam logic [7:0] FLC_CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] FLC_CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] FLC_CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] FLC_CMD_BUF_PROG = 8'he8;
   localparam logic [7:0] FLC_CMD_PROG_A = 8'h40;
   localparam logic [7:0] FLC_CMD_PROG_B = 8'h10;
   localparam logic [7:0] FLC_CMD_ERASE = 8'h20;
   localparam logic [7:0] FLC_CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] FLC_CMD_CONFIRM = 8'hd0;
   localparam logic [7:0] FLC_CMD_CONFIG = 8'hb8;
   localparam logic [7:0] FLC_CMD_LOCK = 8'h60;
   localparam logic [7:0] FLC_CMD_LOCK_SET = 8'h01;
   localparam logic [7:0] FLC_CMD_PROT_PROG = 8'hc0;

   localparam logic [4:0] FLC_BUF_MAX_WORD = 5'h0f;
   localparam logic [4:0] FLC_BUF_MAX_BYTE = 5'h1f;

   localparam logic [1:0] FLC_OP_READ = 2'h0;
   localparam logic [1:0] FLC_OP_WRITE = 2'h1;
   localparam logic [1:0] FLC_OP_RESET = 2'h2;

   typedef enum logic [2:0] {ST_RST, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} flc_bus_t;
   typedef enum logic [2:0] {SQ_IDLE, SQ_ERASE, SQ_LOCK, SQ_DATA, SQ_BUF_WAIT, SQ_BUF_CNT, SQ_BUF_DATA,
                             SQ_BUF_CONF} flc_seq_t;

   typedef struct packed {
      logic [1:0] op;
      logic [FLC_AW-1:0] addr;
      logic [FLC_DW-1:0] data;
   } flc_req_t;

   typedef struct packed {
      logic chip_select_0;
      logic chip_select_1;
      logic chip_select_2;
      logic oe_n;
      logic we_n;
      logic reset_powerdown_n;
      logic program_enable_supply;
      logic [FLC_AW-1:0] addr;
      logic [FLC_DW-1:0] dq_o;
      logic dq_oe;
   } flc_pins_t;

   typedef struct packed {
      flc_bus_t st;
      flc_seq_t seq;
      flc_pins_t pins;
      flc_req_t req;
      logic [15:0] cnt;
      logic [15:0] since;
      logic [4:0] left;
      logic [FLC_AW-FLC_BLK_LSB-1:0] blk;
      logic rdy;
      logic rsp_valid;
      logic rsp_err;
      logic [FLC_DW-1:0] rsp_data;
      logic [FLC_DW-1:0] dq_s1;
      logic [FLC_DW-1:0] dq_s2;
      logic bz_s1;
      logic bz_s2;
      logic busy;
   } flc_state_t;

   // flash held in reset/power-down, bus idle and deselected
   localparam flc_state_t FLC_STATE_RST = '{
      st: ST_RST,
      seq: SQ_IDLE,
      pins: '{chip_select_0: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0},
      // busy pin idles high; a low reset value would flag a false busy after reset
      bz_s1: 1'b1,
      bz_s2: 1'b1,
      default: '0
   };
endpackage : flc_pkg

`default_nettype wire

// >>> bench/flc_flash_model.sv
// behavioural flash partner: command decode, read modes, busy pin
// assumes flc_host pins; chip_select_1/2 are held low by the host
`default_nettype none

module flc_flash_model
   import flc_pkg::*;
(
   input wire flc_pins_t FLASH,
   output logic [FLC_DW-1:0] DQ_I,
   output logic BUSY_STATUS_PIN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mode = 8'hff;
   logic [15:0] junk = 16'h5a5a;
   logic cnt_next = 1'b0;
   int skip = 0;
   time done_at = 0;
   wire logic sel = !FLASH.chip_select_0 && FLASH.reset_powerdown_n;
   // floating lines wander so a stale value never passes for data
   always begin
      BUSY_STATUS_PIN = $time >= done_at;
      junk = junk + 16'h3b1d;
      #3;
   end
   always @(negedge FLASH.reset_powerdown_n) begin
      done_at = 0;
      cnt_next = 1'b0;
      skip = 0;
   end
   always @(posedge FLASH.reset_powerdown_n) mode = 8'hff;
   always @(posedge FLASH.we_n) begin
      if (sel) begin
         if (cnt_next) begin
            skip = FLASH.dq_o[4:0] + 1;
            cnt_next = 1'b0;
         end else if (skip > 0) begin
            skip--;
         end else begin
            case (FLASH.dq_o[7:0])
               8'hff, 8'h90, 8'h98, 8'h70: mode = FLASH.dq_o[7:0];
               8'he8: begin
                  mode = 8'h70;
                  cnt_next = 1'b1;
               end
               8'h40, 8'h10, 8'hc0, 8'hb8: skip = 1;
               8'hd0: if (FLASH.program_enable_supply) begin
                  mode = 8'h70;
                  done_at = $time + 600;
               end
               default: ;
            endcase
         end
      end
   end
   always @* begin
      if (!sel || FLASH.oe_n) DQ_I = junk;
      else if (mode == 8'h70) DQ_I = BUSY_STATUS_PIN ? 16'h0080 : {junk[15:8], 1'b0, junk[6:0]};
      else if (mode == 8'hff) DQ_I = FLASH.addr[16:1] ^ 16'hc3a5;
      else DQ_I = {mode, FLASH.addr[7:0]};
   end
endmodule : flc_flash_model

`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench of flc_host against the behavioural flash
// assumes flc_pkg and flc_flash_model; short reset figures keep the run brief
`default_nettype none

module testbench
   import flc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic err; logic [15:0] mask; logic [15:0] data;} flc_exp_t;
   logic MCLK = 1'b0;
   logic ARST_N = 1'b1;
   logic REQ_VALID = 1'b0;
   flc_req_t REQ = '0;
   logic PROGRAM_ALLOW = 1'b0;
   logic REQ_READY, RSP_VALID, RSP_ERR, FLASH_BUSY, BUSY_STATUS_PIN;
   logic [FLC_DW-1:0] RSP_DATA, DQ_I;
   flc_pins_t FLASH;
   flc_exp_t exp_q[$];
   flc_exp_t e;
   int errors = 0;
   int checked = 0;
   int seed = 84;
   logic [23:0] a, b;
   logic [15:0] d;
   logic [4:0] n;
   logic [7:0] alt_codes[6] = '{8'he8, 8'h40, 8'h10, 8'h20, 8'h60, 8'hc0};
   logic [7:0] setup[4] = '{8'h40, 8'h10, 8'hc0, 8'hb8};

   always #4 MCLK = ~MCLK;

   flc_host #(.RESET_LOW_MIN_NS(200), .RESET_TO_WRITE_NS(80), .RESET_TO_READ_NS(40), .BYTE_MODE(1'b0)) u_dut (
      .MCLK(MCLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
      .RSP_VALID(RSP_VALID), .RSP_ERR(RSP_ERR), .RSP_DATA(RSP_DATA), .PROGRAM_ALLOW(PROGRAM_ALLOW),
      .FLASH(FLASH), .DQ_I(DQ_I), .BUSY_STATUS_PIN(BUSY_STATUS_PIN), .FLASH_BUSY(FLASH_BUSY));
   flc_flash_model u_flash (.FLASH(FLASH), .DQ_I(DQ_I), .BUSY_STATUS_PIN(BUSY_STATUS_PIN));

   task automatic cmp_bit(input logic got, input logic want);
      checked++;
      if (got !== want) begin
         errors++;
         $display("[ERR] t=%0t flag got %h want %h", $time, got, want);
      end
   endtask : cmp_bit
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] want);
      checked++;
      if (got !== want) begin
         errors++;
         $display("[ERR] t=%0t data got %h want %h", $time, got, want);
      end
   endtask : cmp_word
   task automatic give_verdict;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // request held until taken; answer checked later by the monitor
   task automatic req(input logic [1:0] op, input logic [23:0] ad, input logic [15:0] dt, input logic err,
                      input logic [15:0] mask, input logic [15:0] want);
      int i = 0;
      exp_q.push_back('{err, mask, want & mask});
      @(posedge MCLK);
      #1;
      REQ_VALID = 1'b1;
      REQ = '{op, ad, dt};
      @(posedge MCLK);
      while (REQ_READY !== 1'b1 && i < 400) begin
         @(posedge MCLK);
         i++;
      end
      cmp_bit(REQ_READY, 1'b1);
      #1;
      REQ_VALID = 1'b0;
   endtask : req
   task automatic wr(input logic [23:0] ad, input logic [15:0] dt, input logic err);
      req(FLC_OP_WRITE, ad, dt, err, 16'h0, 16'h0);
   endtask : wr
   task automatic rd(input logic [23:0] ad, input logic [15:0] mask, input logic [15:0] want);
      req(FLC_OP_READ, ad, 16'h0, 1'b0, mask, want);
   endtask : rd
   task automatic rst_op;
      req(FLC_OP_RESET, 24'h0, 16'h0, 1'b0, 16'h0, 16'h0);
   endtask : rst_op
   task automatic wait_busy(input logic level);
      int i = 0;
      while (FLASH_BUSY !== level && i < 300) begin
         @(posedge MCLK);
         i++;
      end
      cmp_bit(FLASH_BUSY, level);
   endtask : wait_busy

   always @(posedge MCLK) begin
      if (RSP_VALID === 1'b1) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("[ERR] t=%0t stray answer got %h want %h", $time, RSP_DATA, 16'h0);
         end else begin
            e = exp_q.pop_front();
            cmp_bit(RSP_ERR, e.err);
            cmp_word(RSP_DATA & e.mask, e.data);
         end
      end
   end

   initial begin
      #200000;
      errors++;
      $display("[ERR] t=%0t watchdog got %h want %h", $time, 1'b0, 1'b1);
      give_verdict;
   end

   initial begin
      exp_q.push_back('0);
      // a real falling edge, so the asynchronous reset acts before the first clock
      #1;
      ARST_N = 1'b0;
      repeat (3) @(posedge MCLK);
      cmp_bit(FLASH.reset_powerdown_n, 1'b0);
      #1;
      ARST_N = 1'b1;
      a = 24'($random(seed));
      b = {a[23:17], 17'h0};
      rd(a, 16'hffff, a[16:1] ^ 16'hc3a5);
      wr(a, 16'hab70, 1'b0);
      rd(a, 16'hffff, 16'h0080);
      wr(a, 16'h0050, 1'b0);
      wr(a, 16'h0090, 1'b0);
      rd(a, 16'hffff, {8'h90, a[7:0]});
      wr(a, 16'h0098, 1'b0);
      rd(a, 16'hffff, {8'h98, a[7:0]});
      wr(a, 16'h00ff, 1'b0);
      rd(a, 16'hffff, a[16:1] ^ 16'hc3a5);
      wr(a, 16'h0033, 1'b1);
      foreach (alt_codes[i]) wr(a, {8'h00, alt_codes[i]}, 1'b1);
      PROGRAM_ALLOW = 1'b1;
      foreach (setup[i]) begin
         d = 16'($random(seed));
         wr(a, {8'h00, setup[i]}, 1'b0);
         wr(a, d, 1'b0);
      end
      wr(a, 16'h0020, 1'b0);
      wr(a ^ 24'h020000, 16'h00d0, 1'b1);
      wr(a, 16'h00d0, 1'b0);
      wait_busy(1'b1);
      rd(a, 16'h0080, 16'h0000);
      cmp_bit(FLASH_BUSY, 1'b1);
      wr(a, 16'h00b0, 1'b0);
      wr(a, 16'h00d0, 1'b0);
      wait_busy(1'b0);
      rd(a, 16'hffff, 16'h0080);
      wr(a, 16'h0060, 1'b0);
      wr(a, 16'h0005, 1'b1);
      rst_op;
      wr(a, 16'h0060, 1'b0);
      wr(b, 16'h0001, 1'b0);
      wr(a, 16'h0060, 1'b0);
      wr(a, 16'h00d0, 1'b0);
      wait_busy(1'b1);
      rst_op;
      wait_busy(1'b0);
      rd(a, 16'hffff, a[16:1] ^ 16'hc3a5);
      wr(b, 16'h00e8, 1'b0);
      wr(b, 16'h0003, 1'b1);
      rst_op;
      for (int k = 0; k < 3; k++) begin
         n = (k == 1) ? 5'h0f : 5'($random(seed) & 15);
         wait_busy(1'b0);
         wr(b, 16'h00e8, 1'b0);
         rd(b, 16'h0080, 16'h0080);
         wr(b, (k == 2) ? 16'h0010 : {11'h0, n}, k == 2);
         for (int j = 0; j <= n && k < 2; j++) wr(b + 24'(2 * j), 16'($random(seed)), 1'b0);
         if (k < 2) wr(b, k ? 16'h00d0 : 16'h00ff, k == 0);
         if (k != 1) rst_op;
         else wait_busy(1'b1);
      end
      for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge MCLK);
      cmp_bit(exp_q.size() == 0, 1'b1);
      cmp_bit(FLASH.chip_select_0, 1'b1);
      cmp_bit(FLASH.dq_oe, 1'b0);
      give_verdict;
   end
endmodule : testbench

`default_nettype wire
